// file: rtl/ddr_host_pkg.sv
// constants, types and timing counts for the double-data-rate dram host
// assumes a 100 MHz system clock and a link clock made by dividing it by two
package ddr_host_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 14;
    localparam int AUTO_PRE_BIT = 10;
    localparam int TIMER_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // clocks: the link clock is the system clock divided by two
    localparam int CLK_PERIOD_PS = 10000;
    localparam int LINK_DIV = 2;
    localparam int LINK_PERIOD_PS = CLK_PERIOD_PS * LINK_DIV;

    // device timing, plain defaults in picoseconds or link clock cycles
    localparam int ROW_PRECHARGE_TIME_PS = 15000;
    localparam int ACTIVATE_TO_COLUMN_DELAY_PS = 15000;
    localparam int REFRESH_CYCLE_TIME_PS = 195000;
    localparam int WRITE_RECOVERY_TIME_PS = 15000;
    localparam int WRITE_TO_READ_TIME_PS = 7500;
    localparam int MODE_REGISTER_SET_DELAY_CK = 2;
    localparam int CAS_LATENCY = 5;
    localparam int BURST_LENGTH = 4;
    localparam int WTR_FLOOR_CK = 2;

    // least times round up to whole link cycles, never below one
    localparam int RP_I = (ROW_PRECHARGE_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RCD_I = (ACTIVATE_TO_COLUMN_DELAY_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RFC_I = (REFRESH_CYCLE_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int WR_I = (WRITE_RECOVERY_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int WTR_I = (WRITE_TO_READ_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int WTR_CK = (WTR_I > WTR_FLOOR_CK) ? WTR_I : WTR_FLOOR_CK;
    localparam int HALF_BURST = BURST_LENGTH / 2;

    // each count is stored minus one: a state loaded with n lasts n+1 link cycles
    localparam logic [TIMER_W-1:0] RP_CK = TIMER_W'((RP_I > 1 ? RP_I : 1) - 1);
    localparam logic [TIMER_W-1:0] RCD_CK = TIMER_W'((RCD_I > 1 ? RCD_I : 1) - 1);
    localparam logic [TIMER_W-1:0] RFC_CK = TIMER_W'((RFC_I > 1 ? RFC_I : 1) - 1);
    localparam logic [TIMER_W-1:0] MRD_CK = TIMER_W'(MODE_REGISTER_SET_DELAY_CK - 1);
    localparam logic [TIMER_W-1:0] RD_TO_RD_CK = TIMER_W'(HALF_BURST - 1);
    localparam logic [TIMER_W-1:0] RD_TO_WR_CK = TIMER_W'(HALF_BURST + 2 - 1);
    localparam logic [TIMER_W-1:0] WR_TO_RD_CK = TIMER_W'(CAS_LATENCY - 1 + HALF_BURST + WTR_CK - 1);
    localparam logic [TIMER_W-1:0] WR_TO_WR_CK = TIMER_W'(HALF_BURST - 1);
    localparam logic [TIMER_W-1:0] RD_ACCESS_CK = TIMER_W'(HALF_BURST - 1);
    localparam logic [TIMER_W-1:0] WR_ACCESS_CK = TIMER_W'(CAS_LATENCY - 1 + HALF_BURST + WR_I - 1);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // pin codes {select_n, row_strobe_n, column_strobe_n, write_enable_n}
    localparam logic [3:0] PINS_ACT = 4'h3;
    localparam logic [3:0] PINS_RD = 4'h5;
    localparam logic [3:0] PINS_WR = 4'h4;
    localparam logic [3:0] PINS_PRE = 4'h2;
    localparam logic [3:0] PINS_REF = 4'h1;
    localparam logic [3:0] PINS_LMR = 4'h0;
    localparam logic [3:0] PINS_NOP = 4'h7;
    localparam logic [3:0] PINS_DESEL = 4'hF;

    typedef enum logic [2:0] {
        CMD_ACT = 3'h0,
        CMD_RD = 3'h1,
        CMD_WR = 3'h2,
        CMD_PRE = 3'h3,
        CMD_PRE_ALL = 3'h4,
        CMD_REF = 3'h5,
        CMD_LMR = 3'h6
    } cmd_t;

    typedef enum logic [2:0] {
        BANK_IDLE = 3'h0,
        BANK_ACTIVATING = 3'h1,
        BANK_ACTIVE = 3'h2,
        BANK_BURST = 3'h3,
        BANK_AP_ACCESS = 3'h4,
        BANK_PRECHARGING = 3'h5
    } bank_st_t;

    typedef enum logic {
        RUN_OPEN = 1'b0,
        RUN_HOLD = 1'b1
    } run_t;

endpackage

// file: rtl/bank_track_if.sv
// bundle between the command sequencer and the per-bank tracker
// assumes both ends sit on the system clock
`timescale 1ns/1ps
interface bank_track_if;
    import ddr_host_pkg::*;
    logic issue;
    cmd_t kind;
    logic [BANK_W-1:0] bank;
    logic ap;
    logic [NUM_BANKS-1:0] idle_v;
    logic [NUM_BANKS-1:0] active_v;
    logic [NUM_BANKS-1:0] prech_v;
    modport ctrl (output issue, output kind, output bank, output ap,
                  input idle_v, input active_v, input prech_v);
    modport trk (input issue, input kind, input bank, input ap,
                 output idle_v, output active_v, output prech_v);
endinterface

// file: rtl/bank_tracker.sv
// per-bank state and timer for the eight banks of the attached dram
// assumes issue is already qualified by the link tick and clock enable
`timescale 1ns/1ps
module bank_tracker
    import ddr_host_pkg::*;
(
    // clock, reset and link tick
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    // sequencer side
    bank_track_if.trk trk
);

    ////////////////////////////////////////////////////////////////////////////
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++)
        begin : g_bank
            bank_st_t st_q;
            bank_st_t st_d;
            logic [TIMER_W-1:0] tm_q;
            logic [TIMER_W-1:0] tm_d;
            wire hit = trk.issue && (trk.bank == BANK_W'(b));
            wire all_hit = trk.issue && (trk.kind == CMD_PRE_ALL);
            wire expired = (tm_q == TIMER_ZERO);

            always_comb
            begin
                st_d = st_q;
                tm_d = expired ? tm_q : TIMER_W'(tm_q - TIMER_ONE);
                if (expired)
                begin
                    unique case (st_q)
                        BANK_IDLE: st_d = BANK_IDLE;
                        BANK_ACTIVATING: st_d = BANK_ACTIVE; // see R03 see R15
                        BANK_ACTIVE: st_d = BANK_ACTIVE;
                        BANK_BURST: st_d = BANK_ACTIVE; // see R15
                        BANK_AP_ACCESS:
                        begin
                            st_d = BANK_PRECHARGING; // see R16 see R17
                            tm_d = RP_CK;
                        end
                        BANK_PRECHARGING: st_d = BANK_IDLE; // see R01 see R02 see R04
                        default: st_d = BANK_IDLE;
                    endcase
                end
                if (all_hit)
                begin
                    st_d = BANK_PRECHARGING; // see R07
                    tm_d = RP_CK;
                end
                else if (hit)
                begin
                    unique case (trk.kind)
                        CMD_ACT:
                        begin
                            st_d = BANK_ACTIVATING; // see R03
                            tm_d = RCD_CK;
                        end
                        CMD_RD:
                        begin
                            st_d = trk.ap ? BANK_AP_ACCESS : BANK_BURST; // see R02 see R16
                            tm_d = RD_ACCESS_CK;
                        end
                        CMD_WR:
                        begin
                            // recovery held in the access period so precharge waits it out
                            st_d = trk.ap ? BANK_AP_ACCESS : BANK_BURST; // see R04 see R17
                            tm_d = WR_ACCESS_CK;
                        end
                        CMD_PRE:
                        begin
                            st_d = BANK_PRECHARGING; // see R01
                            tm_d = RP_CK;
                        end
                        default:
                        begin
                            st_d = st_d;
                        end
                    endcase
                end
            end

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    st_q <= BANK_IDLE;
                    tm_q <= TIMER_ZERO;
                end
                else if (tick)
                begin
                    st_q <= st_d; // see R24
                    tm_q <= tm_d;
                end
            end

            assign trk.idle_v[b] = (st_q == BANK_IDLE);
            assign trk.active_v[b] = (st_q == BANK_ACTIVE);
            assign trk.prech_v[b] = (st_q == BANK_PRECHARGING);
        end
    endgenerate

endmodule // bank_tracker

// file: rtl/ddr_host_ctrl.sv
// host-side command sequencer for an eight-bank double-data-rate dram
// assumes the user holds a request steady until it is accepted or refused
// the link clock is made here by dividing clk, so it is no second domain
//
// Contract
// R01 - precharge keeps the bank precharging for row_precharge_time, then idle
// R02 - read with auto precharge keeps bank busy until row_precharge_time met
// R03 - activate keeps bank activating for activate_to_column_delay, then row active
// R04 - write with auto precharge keeps bank busy until row_precharge_time met
// R05 - refresh blocks the whole device for refresh_cycle_time; banks idle after
// R06 - load mode blocks for mode_register_set_delay; only deselect meanwhile
// R07 - precharge all puts every bank precharging for row_precharge_time
// R08 - during refresh, mode access, precharge all: deselect or nop only
// R09 - never issue a state and command pair outside the permitted tables
// R10 - refresh and load mode only when all banks idle, no burst running
// R11 - write after read only once the read burst has completed
// R12 - with one bank busy, other banks take legal commands for their state
// R13 - strobe codes: activate 0011, read 0101, write 0100, precharge 0010, nop 0111
// R14 - alternate-bank commands only with clock enable high two cycles running
// R15 - bank is row active after activate delay with no burst in progress
// R16 - read auto precharge starts at the earliest legal explicit precharge
// R17 - write auto precharge starts when write_recovery_time ends
// R18 - during auto precharge other banks accept commands not breaking transfers
// R19 - keep read and write data off the bus together; all timing holds
// R20 - write-to-read turnaround is max of two and write_to_read_time cycles
// R21 - after write autoprecharge: read cl-1+bl/2+wtr, write bl/2, else one
// R22 - after read autoprecharge: read bl/2, write bl/2+2, precharge/activate one
// R23 - every command is sampled from the strobes at the rising link clock edge
// R24 - separate state and timer per bank plus a device-wide busy tracker
// R25 - select high makes the device ignore commands; work in progress goes on
`timescale 1ns/1ps
module ddr_host_ctrl
    import ddr_host_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // user request
    input wire logic req_valid,
    input wire ddr_host_pkg::cmd_t req_cmd,
    input wire logic [ddr_host_pkg::BANK_W-1:0] req_bank,
    input wire logic [ddr_host_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_ap,
    // user answer
    output logic req_accept_q,
    output logic req_error_q,
    output logic busy_q,
    // dram pins
    output logic ck_q,
    output logic cke_q,
    output logic cs_n_q,
    output logic ras_n_q,
    output logic cas_n_q,
    output logic we_n_q,
    output logic [ddr_host_pkg::BANK_W-1:0] ba_q,
    output logic [ddr_host_pkg::ADDR_W-1:0] addr_q
);
    import ddr_host_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    bank_track_if trk_bus ();

    run_t run_q;
    run_t run_d;
    logic [TIMER_W-1:0] hold_q;
    logic [TIMER_W-1:0] hold_d;
    logic [TIMER_W-1:0] rd_gap_q;
    logic [TIMER_W-1:0] rd_gap_d;
    logic [TIMER_W-1:0] wr_gap_q;
    logic [TIMER_W-1:0] wr_gap_d;
    logic cke_prev_q;
    logic [3:0] pins_d;
    logic [ADDR_W-1:0] addr_d;

    ////////////////////////////////////////////////////////////////////////////
    // link clock and command slot
    // commands change as ck falls, so they sit still across the rising edge
    wire tick = ce && ck_q; // see R23

    // clock enable on the pin must have been high last cycle and this one
    wire cke_ok = cke_q && cke_prev_q; // see R14

    wire holding = (run_q == RUN_HOLD); // see R08

    ////////////////////////////////////////////////////////////////////////////
    // decoding of the request against bank state
    wire [NUM_BANKS-1:0] settled_v = trk_bus.idle_v | trk_bus.active_v | trk_bus.prech_v;
    wire bank_idle = trk_bus.idle_v[req_bank];
    wire bank_active = trk_bus.active_v[req_bank];
    wire bank_prech = trk_bus.prech_v[req_bank];
    wire bank_settled = settled_v[req_bank];
    wire all_idle = &trk_bus.idle_v;
    wire all_settled = &settled_v;
    wire bursts_done = (rd_gap_q == TIMER_ZERO) && (wr_gap_q == TIMER_ZERO);

    // other banks are judged by their own state and the shared column gaps, so a busy bank blocks them only through those gaps
    wire act_ok = bank_idle; // see R12
    wire act_bad = !bank_idle && !bank_prech;
    wire rd_ok = bank_active && (rd_gap_q == TIMER_ZERO); // see R12 see R18 see R19
    wire wr_ok = bank_active && (wr_gap_q == TIMER_ZERO); // see R11 see R19
    wire col_bad = bank_idle || bank_prech;
    wire pre_ok = bank_settled;
    wire pre_all_ok = all_settled;
    wire ref_lmr_ok = all_idle && bursts_done; // see R10

    wire is_act = (req_cmd == CMD_ACT);
    wire is_rd = (req_cmd == CMD_RD);
    wire is_wr = (req_cmd == CMD_WR);
    wire is_pre = (req_cmd == CMD_PRE);
    wire is_pre_all = (req_cmd == CMD_PRE_ALL);
    wire is_ref = (req_cmd == CMD_REF);
    wire is_lmr = (req_cmd == CMD_LMR);
    wire is_known = is_act || is_rd || is_wr || is_pre || is_pre_all || is_ref || is_lmr;

    wire cmd_ok = (is_act && act_ok)
                  || (is_rd && rd_ok)
                  || (is_wr && wr_ok)
                  || (is_pre && pre_ok)
                  || (is_pre_all && pre_all_ok)
                  || ((is_ref || is_lmr) && ref_lmr_ok);

    // pairs outside the tables are refused rather than sent
    wire cmd_bad = !is_known
                   || (is_act && act_bad)
                   || ((is_rd || is_wr) && col_bad); // see R09

    wire slot = tick && req_valid && cke_ok && !holding;
    wire issue = slot && cmd_ok && !cmd_bad;
    wire refuse = slot && cmd_bad;

    ////////////////////////////////////////////////////////////////////////////
    // pin encoding
    wire [3:0] pins_cmd = is_act ? PINS_ACT
                          : is_rd ? PINS_RD
                          : is_wr ? PINS_WR
                          : (is_pre || is_pre_all) ? PINS_PRE
                          : is_ref ? PINS_REF
                          : is_lmr ? PINS_LMR
                          : PINS_NOP; // see R13

    always_comb
    begin
        addr_d = req_addr;
        if (is_rd || is_wr)
        begin
            addr_d[AUTO_PRE_BIT] = req_ap;
        end
        if (is_pre || is_pre_all)
        begin
            addr_d[AUTO_PRE_BIT] = is_pre_all;
        end
        // deselect whenever nothing is sent; the device carries on regardless
        pins_d = issue ? pins_cmd : PINS_DESEL; // see R25 see R08
    end

    ////////////////////////////////////////////////////////////////////////////
    // device-wide busy period for refresh, mode access and precharge all
    always_comb
    begin
        run_d = run_q;
        hold_d = hold_q;
        if (holding)
        begin
            if (hold_q == TIMER_ZERO)
            begin
                run_d = RUN_OPEN;
            end
            else
            begin
                hold_d = TIMER_W'(hold_q - TIMER_ONE);
            end
        end
        if (issue && is_ref)
        begin
            run_d = RUN_HOLD; // see R05
            hold_d = RFC_CK;
        end
        if (issue && is_lmr)
        begin
            run_d = RUN_HOLD; // see R06
            hold_d = MRD_CK;
        end
        if (issue && is_pre_all)
        begin
            run_d = RUN_HOLD; // see R07 see R08
            hold_d = RP_CK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // column spacing shared by all banks
    // applied to plain and auto-precharge bursts alike, which is safe but not tight
    always_comb
    begin
        rd_gap_d = (rd_gap_q == TIMER_ZERO) ? rd_gap_q : TIMER_W'(rd_gap_q - TIMER_ONE);
        wr_gap_d = (wr_gap_q == TIMER_ZERO) ? wr_gap_q : TIMER_W'(wr_gap_q - TIMER_ONE);
        if (issue && is_rd)
        begin
            rd_gap_d = RD_TO_RD_CK; // see R22
            wr_gap_d = RD_TO_WR_CK; // see R22 see R11
        end
        if (issue && is_wr)
        begin
            rd_gap_d = WR_TO_RD_CK; // see R20 see R21
            wr_gap_d = WR_TO_WR_CK; // see R21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bank tracker
    assign trk_bus.issue = issue;
    assign trk_bus.kind = req_cmd;
    assign trk_bus.bank = req_bank;
    assign trk_bus.ap = req_ap;

    bank_tracker u_bank_tracker (
        .clk(clk),
        .reset(reset),
        .tick(tick),
        .trk(trk_bus.trk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link clock divider and clock enable
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ck_q <= 1'b0;
            cke_q <= 1'b0;
            cke_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            ck_q <= !ck_q;
            if (tick)
            begin
                cke_q <= 1'b1;
                cke_prev_q <= cke_q; // see R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command pins
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= PINS_DESEL;
            ba_q <= '0;
            addr_q <= '0;
        end
        else if (tick)
        begin
            {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= pins_d; // see R23
            if (issue)
            begin
                ba_q <= req_bank;
                addr_q <= addr_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timers and run state
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            run_q <= RUN_OPEN;
            hold_q <= TIMER_ZERO;
            rd_gap_q <= TIMER_ZERO;
            wr_gap_q <= TIMER_ZERO;
            busy_q <= 1'b0;
        end
        else if (tick)
        begin
            run_q <= run_d; // see R24
            hold_q <= hold_d;
            rd_gap_q <= rd_gap_d;
            wr_gap_q <= wr_gap_d;
            busy_q <= (run_d == RUN_HOLD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // user answer: one-cycle pulses, the request is held until one of them
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            req_accept_q <= 1'b0;
            req_error_q <= 1'b0;
        end
        else if (ce)
        begin
            req_accept_q <= issue;
            req_error_q <= refuse; // see R09
        end
    end

endmodule // ddr_host_ctrl

// file: testbench/ddr_host_props.sv
// timing checks on the pins and answers of the dram host sequencer
// assumes ce is held high, so every pulse lasts one cycle
`timescale 1ns/1ps
module ddr_host_props
    import ddr_host_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // user side
    input wire logic [ddr_host_pkg::BANK_W-1:0] req_bank,
    input wire logic req_ap,
    input wire logic req_accept_q,
    input wire logic req_error_q,
    input wire logic busy_q,
    // dram pins
    input wire logic ck_q,
    input wire logic cke_q,
    input wire logic cs_n_q,
    input wire logic ras_n_q,
    input wire logic cas_n_q,
    input wire logic we_n_q,
    input wire logic [ddr_host_pkg::BANK_W-1:0] ba_q,
    input wire logic [ddr_host_pkg::ADDR_W-1:0] addr_q
);
    wire [3:0] pins = {cs_n_q, ras_n_q, cas_n_q, we_n_q};
    wire col_sent = req_accept_q && (pins == PINS_RD || pins == PINS_WR);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_quiet8; cs_n_q [*8]; endsequence
    sequence s_ref_sent; req_accept_q && pins == PINS_REF; endsequence
    sequence s_lmr_sent; req_accept_q && pins == PINS_LMR; endsequence
    property p_ref_hold; s_ref_sent |-> ##2 s_quiet8 ##1 s_quiet8; endproperty
    property p_lmr_hold; s_lmr_sent |-> ##2 cs_n_q [*2]; endproperty
    property p_pulse; req_accept_q |=> !req_accept_q && !req_error_q; endproperty
    property p_cmd_stands; req_accept_q |-> !cs_n_q ##1 ($stable(pins) && !cs_n_q); endproperty
    property p_pins_on_fall; !$stable(pins) |-> $fell(ck_q); endproperty
    property p_busy_quiet; busy_q && $past(busy_q, 2) |-> cs_n_q; endproperty
    property p_error_nothing; req_error_q |-> cs_n_q; endproperty
    property p_bank; col_sent || (req_accept_q && pins == PINS_ACT) |-> ba_q == $past(req_bank);
    endproperty
    property p_ap_bit; col_sent |-> addr_q[AUTO_PRE_BIT] == $past(req_ap); endproperty
    property p_cke; !cs_n_q |-> cke_q && $past(cke_q, 2); endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("refresh hold broken");
    a_lmr_hold: assert property (p_lmr_hold) else $error("mode hold broken");
    a_pulse: assert property (p_pulse) else $error("answer pulse too long");
    a_cmd_stands: assert property (p_cmd_stands) else $error("command not held");
    a_pins_on_fall: assert property (p_pins_on_fall) else $error("pins off fall");
    a_busy_quiet: assert property (p_busy_quiet) else $error("command in hold");
    a_error_nothing: assert property (p_error_nothing) else $error("refused but sent");
    a_bank: assert property (p_bank) else $error("wrong bank sent");
    a_ap_bit: assert property (p_ap_bit) else $error("wrong auto precharge bit");
    a_cke: assert property (p_cke) else $error("command without clock enable");
endmodule // ddr_host_props
bind ddr_host_ctrl ddr_host_props u_ddr_host_props (.clk(clk), .reset(reset),
    .req_bank(req_bank), .req_ap(req_ap), .req_accept_q(req_accept_q),
    .req_error_q(req_error_q), .busy_q(busy_q), .ck_q(ck_q), .cke_q(cke_q),
    .cs_n_q(cs_n_q), .ras_n_q(ras_n_q), .cas_n_q(cas_n_q), .we_n_q(we_n_q),
    .ba_q(ba_q), .addr_q(addr_q));

// file: testbench/ddr_dev_model.sv
// behavioural eight-bank dram that counts the illegal commands it checks: row state, turnaround, hold and clock enable
// assumes the host makes ck and changes pins only on its fall
`timescale 1ns/1ps
module ddr_dev_model
    import ddr_host_pkg::*;
(
    // link pins
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ddr_host_pkg::BANK_W-1:0] ba,
    input wire logic [ddr_host_pkg::ADDR_W-1:0] addr,
    // fault count
    output int faults
);
    logic [NUM_BANKS-1:0] open_q; // one row flag per bank
    int hold_q = 0;
    int since_wr = 100;
    int since_rd = 100;
    wire [3:0] code = {cs_n, ras_n, cas_n, we_n};
    wire any_cmd = !cs_n && code != PINS_NOP; // deselect changes nothing
    initial faults = 0;
    initial open_q = '0;
    always @(posedge ck) // taken at rising link clock
    begin
        since_wr++;
        since_rd++;
        if (any_cmd && (hold_q > 0 || !cke)) faults++;
        if (hold_q > 0) hold_q--;
        if (any_cmd)
        begin
            case (code)
                PINS_ACT: begin if (open_q[ba]) faults++; open_q[ba] = 1'b1; end
                PINS_RD, PINS_WR:
                begin
                    if (!open_q[ba]) faults++;
                    if (code == PINS_RD && since_wr < WR_TO_RD_CK + 1) faults++;
                    if (code == PINS_WR && since_rd < RD_TO_WR_CK + 1) faults++;
                    if (addr[AUTO_PRE_BIT]) open_q[ba] = 1'b0;
                    if (code == PINS_WR) since_wr = 0;
                    else since_rd = 0;
                end
                PINS_PRE: if (addr[AUTO_PRE_BIT]) open_q = '0; else open_q[ba] = 1'b0;
                PINS_REF, PINS_LMR:
                begin
                    if (open_q != '0) faults++;
                    hold_q = (code == PINS_REF) ? RFC_CK : MRD_CK;
                end
                default: faults++;
            endcase
        end
    end
endmodule // ddr_dev_model

// file: testbench/ddr_host_ctrl_test.sv
// self-checking bench for the dram host sequencer
// assumes the device model flags every illegal command it checks: row state, turnaround, hold and clock enable
`timescale 1ns/1ps
module ddr_host_ctrl_test;
    import ddr_host_pkg::*;
    logic clk, reset, ce, req_valid, req_ap, req_accept_q, req_error_q, busy_q;
    logic ck_q, cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q;
    cmd_t req_cmd;
    logic [BANK_W-1:0] req_bank, ba_q, a, b;
    logic [ADDR_W-1:0] req_addr, addr_q;
    int mismatches, n_compared, cyc, faults, t_acc, t0;
    logic [31:0] exp_q[$];
    ddr_host_ctrl u_ddr_host_ctrl (.clk(clk), .reset(reset), .ce(ce), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_ap(req_ap),
        .req_accept_q(req_accept_q), .req_error_q(req_error_q), .busy_q(busy_q), .ck_q(ck_q),
        .cke_q(cke_q), .cs_n_q(cs_n_q), .ras_n_q(ras_n_q), .cas_n_q(cas_n_q), .we_n_q(we_n_q),
        .ba_q(ba_q), .addr_q(addr_q));
    ddr_dev_model u_ddr_dev_model (.ck(ck_q), .cke(cke_q), .cs_n(cs_n_q), .ras_n(ras_n_q),
        .cas_n(cas_n_q), .we_n(we_n_q), .ba(ba_q), .addr(addr_q), .faults(faults));
    initial begin clk = 0; forever #5 clk = ~clk; end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one edge passes after the drop, so a held request is never taken twice
    task automatic issue(input logic [2:0] c, input logic [2:0] bk, input logic ap, input logic e);
        exp_q.push_back({31'h0, e});
        req_cmd = cmd_t'(c);
        req_bank = bk;
        req_ap = ap;
        req_addr = ADDR_W'($urandom);
        req_valid = 1;
        for (int n = 0; n < 400 && req_accept_q !== 1'b1 && req_error_q !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        t_acc = cyc;
        req_valid = 0;
        @(posedge clk);
        #1;
    endtask
    always @(negedge clk)
    begin
        cyc++;
        if (req_accept_q === 1'b1 || req_error_q === 1'b1)
            check({31'h0, req_error_q}, exp_q.size() ? exp_q.pop_front() : 32'hFFFF);
        if (cyc == 30000) begin mismatches++; conclude(); end
    end
    initial
    begin
        {reset, ce, req_valid, req_ap, req_bank, req_addr, cyc, mismatches, n_compared} = '0;
        reset = 1;
        ce = 1;
        req_cmd = CMD_ACT;
        void'($urandom(32'h069A));
        repeat (20) @(posedge clk);
        #1 reset = 0;
        a = BANK_W'($urandom);
        b = a + BANK_W'(1 + $urandom % 7);
        issue(CMD_ACT, a, 0, 0);
        issue(CMD_RD, b, 0, 1);
        issue(CMD_ACT, a, 0, 1);
        issue(3'h7, a, 0, 1);
        issue(CMD_WR, a, 1, 0);
        t0 = t_acc;
        issue(CMD_ACT, b, 0, 0);
        issue(CMD_RD, b, 1, 0);
        check(t_acc - t0 >= 2 * (WR_TO_RD_CK + 1), 1);
        $display("test 1 done");
        t0 = t_acc;
        issue(CMD_ACT, a, 0, 0);
        issue(CMD_WR, a, 0, 0);
        check(t_acc - t0 >= 2 * (RD_TO_WR_CK + 1), 1);
        issue(CMD_RD, b, 0, 1);
        $display("test 2 done");
        issue(CMD_PRE_ALL, a, 0, 0);
        issue(CMD_REF, a, 0, 0);
        check(busy_q, 1);
        t0 = t_acc;
        issue(CMD_LMR, a, 0, 0);
        check(t_acc - t0 >= 2 * (RFC_CK + 1), 1);
        t0 = t_acc;
        issue(CMD_ACT, b, 0, 0);
        check(t_acc - t0 >= 2 * (MRD_CK + 1), 1);
        issue(CMD_PRE, b, 0, 0);
        $display("test 3 done");
        repeat (20) @(posedge clk);
        check(faults, 0);
        check(exp_q.size(), 0);
        conclude();
    end
endmodule // ddr_host_ctrl_test
